// ### hdl/crg_chan0_regs.sv
// Purpose: Threshold, high-pass and channel 0 configuration and offset registers.
// Assumes: Plain register port, read data valid one cycle after the read strobe.
// Notes: Unmapped reads return zero; unmapped writes are ignored.
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
`include "crg_cfg.svh"

module crg_chan0_regs (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [`CRG_ADDR_W-1:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    output crg_pkg::crg_chan_cfg_s chan_cfg
);

    // ======================================================================
    // Storage
    logic [15:0] thr_high;
    logic [15:0] thr_low;
    logic [15:0] chan0_config;
    logic [15:0] ofs_high;
    logic [15:0] ofs_low;
    logic wr_thr_high;
    logic wr_thr_low;
    logic wr_cfg;
    logic wr_ofs_high;
    logic wr_ofs_low;

    always_comb begin
        wr_thr_high = reg_wr && (reg_addr == `CRG_ADDR_THR_HIGH);
        wr_thr_low = reg_wr && (reg_addr == `CRG_ADDR_THR_LOW);
        wr_cfg = reg_wr && (reg_addr == `CRG_ADDR_CHAN0_CONFIG);
        wr_ofs_high = reg_wr && (reg_addr == `CRG_ADDR_CH0_OFS_HIGH);
        wr_ofs_low = reg_wr && (reg_addr == `CRG_ADDR_CH0_OFS_LOW);
    end

    crg_word_reg #(
        .RST_VAL(`CRG_RST_THR_HIGH),
        .WR_MASK(`CRG_MASK_THR_HIGH)
    ) u_thr_high (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .wr_en(wr_thr_high),
        .wr_data(reg_wdata),
        .value(thr_high)
    );

    crg_word_reg #(
        .RST_VAL(`CRG_RST_THR_LOW),
        .WR_MASK(`CRG_MASK_THR_LOW)
    ) u_thr_low (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .wr_en(wr_thr_low),
        .wr_data(reg_wdata),
        .value(thr_low)
    );

    crg_word_reg #(
        .RST_VAL(`CRG_RST_CHAN0_CONFIG),
        .WR_MASK(`CRG_MASK_CHAN0_CONFIG)
    ) u_cfg (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .wr_en(wr_cfg),
        .wr_data(reg_wdata),
        .value(chan0_config)
    );

    crg_word_reg #(
        .RST_VAL(`CRG_RST_CH0_OFS_HIGH),
        .WR_MASK(`CRG_MASK_CH0_OFS_HIGH)
    ) u_ofs_high (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .wr_en(wr_ofs_high),
        .wr_data(reg_wdata),
        .value(ofs_high)
    );

    crg_word_reg #(
        .RST_VAL(`CRG_RST_CH0_OFS_LOW),
        .WR_MASK(`CRG_MASK_CH0_OFS_LOW)
    ) u_ofs_low (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .wr_en(wr_ofs_low),
        .wr_data(reg_wdata),
        .value(ofs_low)
    );

    // ======================================================================
    // Read port
    logic [15:0] rdata_ff;
    logic [15:0] nxt_rdata;

    always_comb begin
        nxt_rdata = 16'h0000;
        if (reg_rd) begin
            unique case (reg_addr)
                `CRG_ADDR_THR_HIGH: nxt_rdata = thr_high;
                `CRG_ADDR_THR_LOW: nxt_rdata = thr_low;
                `CRG_ADDR_CHAN0_CONFIG: nxt_rdata = chan0_config;
                `CRG_ADDR_CH0_OFS_HIGH: nxt_rdata = ofs_high;
                `CRG_ADDR_CH0_OFS_LOW: nxt_rdata = ofs_low;
                default: nxt_rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rdata_ff <= 16'h0000;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata = rdata_ff;

    // ======================================================================
    // Decoded configuration, registered so the channel sees clean levels
    logic hpf_on;
    logic [3:0] hpf_shift;

    crg_hpf_decode u_hpf (
        .coeff_code(thr_low[`CRG_HPF_MSB:`CRG_HPF_LSB]),
        .bypass(chan0_config[`CRG_BYPASS_BIT]),
        .filter_on(hpf_on),
        .shift_m1(hpf_shift)
    );

    crg_pkg::crg_chan_cfg_s cfg_ff;
    crg_pkg::crg_chan_cfg_s nxt_cfg;

    always_comb begin
        nxt_cfg.detect_threshold = {thr_high,
                                    thr_low[`CRG_THR_LOW_MSB:`CRG_THR_LOW_LSB]};
        nxt_cfg.chan0_phase_delay = chan0_config[`CRG_PHASE_MSB:`CRG_PHASE_LSB];
        nxt_cfg.chan0_highpass_on = hpf_on;
        nxt_cfg.chan0_highpass_shift = hpf_shift;
        nxt_cfg.chan0_input_select =
            crg_pkg::crg_input_e'(chan0_config[`CRG_MUX_MSB:`CRG_MUX_LSB]);
        nxt_cfg.chan0_offset = {ofs_high,
                                ofs_low[`CRG_OFS_LOW_MSB:`CRG_OFS_LOW_LSB]};
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cfg_ff <= '0;
        end else begin
            cfg_ff <= nxt_cfg;
        end
    end

    assign chan_cfg = cfg_ff;

    // ======================================================================
    // Checks
    ofs_low_rsv_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        $past(reg_rd) && $past(reg_addr) == `CRG_ADDR_CH0_OFS_LOW
        |-> reg_rdata[7:0] == 8'h00)
        else $error("Offset low reserved byte not zero.");

    cfg_rsv_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        reg_rd && reg_addr == `CRG_ADDR_CHAN0_CONFIG |=> reg_rdata[5:3] == 3'h0)
        else $error("Config reserved bits not zero.");

    thr_low_rsv_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        reg_rd && reg_addr == `CRG_ADDR_THR_LOW |=> reg_rdata[7:4] == 4'h0)
        else $error("Threshold low reserved bits not zero.");

    ofs_high_wr_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        reg_wr && reg_addr == `CRG_ADDR_CH0_OFS_HIGH
        |=> ##1 chan_cfg.chan0_offset[23:8] == $past(reg_wdata, 2))
        else $error("Offset high write not applied.");

    thr_wr_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        reg_wr && reg_addr == `CRG_ADDR_THR_LOW
        |=> ##1 chan_cfg.detect_threshold[7:0] == $past(reg_wdata[15:8], 2))
        else $error("Threshold low byte write not applied.");

    thr_high_wr_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        reg_wr && reg_addr == `CRG_ADDR_THR_HIGH
        |=> ##1 chan_cfg.detect_threshold[23:8] == $past(reg_wdata, 2))
        else $error("Threshold high write not applied.");

    phase_wr_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        reg_wr && reg_addr == `CRG_ADDR_CHAN0_CONFIG
        |=> ##1 chan_cfg.chan0_phase_delay == $past(reg_wdata[15:6], 2))
        else $error("Phase delay write not applied.");

    mux_wr_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        reg_wr && reg_addr == `CRG_ADDR_CHAN0_CONFIG
        |=> ##1 chan_cfg.chan0_input_select == $past(reg_wdata[1:0], 2))
        else $error("Input select write not applied.");

    hpf_bypass_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        chan0_config[`CRG_BYPASS_BIT] |=> !chan_cfg.chan0_highpass_on)
        else $error("High-pass not bypassed.");

    hpf_code_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        !chan0_config[`CRG_BYPASS_BIT] && thr_low[3:0] != 4'h0
        |=> chan_cfg.chan0_highpass_on
            && chan_cfg.chan0_highpass_shift == $past(thr_low[3:0]))
        else $error("High-pass code not followed.");

    rd_idle_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        !reg_rd |=> reg_rdata == 16'h0000)
        else $error("Read data not zero without a read.");

    // ======================================================================
    // Storage checks
    // Each word keeps only its writable bits, so a wrong mask shows up here first.
    thr_high_store_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        wr_thr_high |=> thr_high == $past(reg_wdata))
        else $error("Threshold high word not stored.");

    thr_low_store_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        wr_thr_low |=> thr_low == ($past(reg_wdata) & `CRG_MASK_THR_LOW))
        else $error("Threshold low word not stored.");

    cfg_store_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        wr_cfg |=> chan0_config == ($past(reg_wdata) & `CRG_MASK_CHAN0_CONFIG))
        else $error("Config word not stored.");

    ofs_high_store_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        wr_ofs_high |=> ofs_high == $past(reg_wdata))
        else $error("Offset high word not stored.");

    ofs_low_store_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        wr_ofs_low |=> ofs_low == ($past(reg_wdata) & `CRG_MASK_CH0_OFS_LOW))
        else $error("Offset low word not stored.");

    // A word may only change on its own write strobe.
    thr_high_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        !wr_thr_high |=> $stable(thr_high))
        else $error("Threshold high word changed without a write.");

    thr_low_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        !wr_thr_low |=> $stable(thr_low))
        else $error("Threshold low word changed without a write.");

    cfg_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        !wr_cfg |=> $stable(chan0_config))
        else $error("Config word changed without a write.");

    ofs_high_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        !wr_ofs_high |=> $stable(ofs_high))
        else $error("Offset high word changed without a write.");

    ofs_low_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        !wr_ofs_low |=> $stable(ofs_low))
        else $error("Offset low word changed without a write.");

    // Addresses outside the slice belong to neighbouring blocks and must not alias here.
    unmapped_wr_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        reg_wr && (reg_addr < `CRG_ADDR_THR_HIGH || reg_addr > `CRG_ADDR_CH0_OFS_LOW)
        |=> $stable(thr_high) && $stable(thr_low) && $stable(chan0_config)
            && $stable(ofs_high) && $stable(ofs_low))
        else $error("Unmapped write changed a register.");

    unmapped_rd_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        reg_rd && (reg_addr < `CRG_ADDR_THR_HIGH || reg_addr > `CRG_ADDR_CH0_OFS_LOW)
        |=> reg_rdata == 16'h0000)
        else $error("Unmapped read returned data.");

    // ======================================================================
    // Read path checks
    rd_thr_high_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        reg_rd && reg_addr == `CRG_ADDR_THR_HIGH |=> reg_rdata == $past(thr_high))
        else $error("Threshold high read wrong.");

    rd_thr_low_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        reg_rd && reg_addr == `CRG_ADDR_THR_LOW |=> reg_rdata == $past(thr_low))
        else $error("Threshold low read wrong.");

    rd_cfg_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        reg_rd && reg_addr == `CRG_ADDR_CHAN0_CONFIG |=> reg_rdata == $past(chan0_config))
        else $error("Config read wrong.");

    rd_ofs_high_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        reg_rd && reg_addr == `CRG_ADDR_CH0_OFS_HIGH |=> reg_rdata == $past(ofs_high))
        else $error("Offset high read wrong.");

    rd_ofs_low_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        reg_rd && reg_addr == `CRG_ADDR_CH0_OFS_LOW |=> reg_rdata == $past(ofs_low))
        else $error("Offset low read wrong.");

    // ======================================================================
    // Decoded output checks
    ofs_low_wr_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        reg_wr && reg_addr == `CRG_ADDR_CH0_OFS_LOW
        |=> ##1 chan_cfg.chan0_offset[7:0] == $past(reg_wdata[15:8], 2))
        else $error("Offset low byte write not applied.");

    bypass_wr_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        reg_wr && reg_addr == `CRG_ADDR_CHAN0_CONFIG && reg_wdata[`CRG_BYPASS_BIT]
        |=> ##1 !chan_cfg.chan0_highpass_on)
        else $error("Bypass write not applied.");

    hpf_off_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        thr_low[`CRG_HPF_MSB:`CRG_HPF_LSB] == `CRG_HPF_OFF
        |=> !chan_cfg.chan0_highpass_on && chan_cfg.chan0_highpass_shift == 4'h0)
        else $error("High-pass not off for code zero.");

    bypass_shift_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        chan0_config[`CRG_BYPASS_BIT] |=> chan_cfg.chan0_highpass_shift == 4'h0)
        else $error("Shift not cleared while bypassed.");

    thr_out_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        chan_cfg.detect_threshold == $past({thr_high, thr_low[15:8]}))
        else $error("Threshold output does not follow the words.");

    ofs_out_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        chan_cfg.chan0_offset == $past({ofs_high, ofs_low[15:8]}))
        else $error("Offset output does not follow the words.");

    phase_out_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        chan_cfg.chan0_phase_delay == $past(chan0_config[15:6]))
        else $error("Phase output does not follow the config word.");

    mux_out_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        chan_cfg.chan0_input_select == $past(chan0_config[1:0]))
        else $error("Input select output does not follow the config word.");

    // The channel reads these levels every sample, so they must not wander between writes.
    cfg_out_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        !reg_wr ##1 !reg_wr |=> $stable(chan_cfg))
        else $error("Decoded configuration changed without a write.");

endmodule
`default_nettype wire

// ### inc/crg_cfg.svh
// Purpose: Offsets, field positions and reset values for the channel 0 register slice.
// Assumes: Word addressed register port, 16-bit words.
// Notes: Definitions only.
`ifndef CRG_CFG_SVH
`define CRG_CFG_SVH

// ==========================================================================
// Word addresses
`define CRG_ADDR_W 6
`define CRG_ADDR_THR_HIGH 6'h07
`define CRG_ADDR_THR_LOW 6'h08
`define CRG_ADDR_CHAN0_CONFIG 6'h09
`define CRG_ADDR_CH0_OFS_HIGH 6'h0a
`define CRG_ADDR_CH0_OFS_LOW 6'h0b

// ==========================================================================
// Reset values
`define CRG_RST_THR_HIGH 16'h0000
`define CRG_RST_THR_LOW 16'h0000
`define CRG_RST_CHAN0_CONFIG 16'h0000
`define CRG_RST_CH0_OFS_HIGH 16'h0000
`define CRG_RST_CH0_OFS_LOW 16'h0000

// ==========================================================================
// Writable bit masks; clear bits are reserved and read zero
`define CRG_MASK_THR_HIGH 16'hffff
`define CRG_MASK_THR_LOW 16'hff0f
`define CRG_MASK_CHAN0_CONFIG 16'hffc7
`define CRG_MASK_CH0_OFS_HIGH 16'hffff
`define CRG_MASK_CH0_OFS_LOW 16'hff00

// ==========================================================================
// Field positions
`define CRG_THR_LOW_MSB 15
`define CRG_THR_LOW_LSB 8
`define CRG_HPF_MSB 3
`define CRG_HPF_LSB 0
`define CRG_PHASE_MSB 15
`define CRG_PHASE_LSB 6
`define CRG_BYPASS_BIT 2
`define CRG_MUX_MSB 1
`define CRG_MUX_LSB 0
`define CRG_OFS_LOW_MSB 15
`define CRG_OFS_LOW_LSB 8
`define CRG_HPF_OFF 4'h0

`endif

// ### inc/crg_pkg.sv
// Purpose: Types shared by the channel 0 register slice.
// Assumes: Nothing beyond the constants header.
// Notes: Types only.
`default_nettype none

package crg_pkg;

    // ======================================================================
    // Input selection codes
    typedef enum logic [1:0] {
        CRG_IN_NORMAL = 2'b00,
        CRG_IN_SHORT = 2'b01,
        CRG_IN_TEST_POS = 2'b10,
        CRG_IN_TEST_NEG = 2'b11
    } crg_input_e;

    // ======================================================================
    // Decoded configuration handed to the converter channel
    typedef struct packed {
        logic [23:0] detect_threshold;
        logic [9:0] chan0_phase_delay;
        logic chan0_highpass_on;
        logic [3:0] chan0_highpass_shift;
        crg_input_e chan0_input_select;
        logic [23:0] chan0_offset;
    } crg_chan_cfg_s;

endpackage

`default_nettype wire

// ### hdl/crg_word_reg.sv
// Purpose: One 16-bit software register with a mask of writable bits.
// Assumes: Write strobe is one cycle long.
// Notes: Reserved bits are held at zero and ignore writes.
`timescale 1ns/1ns
`default_nettype none

module crg_word_reg #(
    parameter logic [15:0] RST_VAL = 16'h0000,
    parameter logic [15:0] WR_MASK = 16'hffff
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic wr_en,
    input wire logic [15:0] wr_data,
    output logic [15:0] value
);

    logic [15:0] word_ff;
    logic [15:0] nxt_word;

    always_comb begin
        nxt_word = word_ff;
        if (wr_en) begin
            nxt_word = wr_data & WR_MASK;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            word_ff <= RST_VAL & WR_MASK;
        end else begin
            word_ff <= nxt_word;
        end
    end

    assign value = word_ff;

endmodule
`default_nettype wire

// ### hdl/crg_hpf_decode.sv
// Purpose: Turns the global high-pass code and channel bypass into a shift amount.
// Assumes: Code zero means the filter is off.
// Notes: Coefficient is 1/2^(code+1), so the shift is code plus one.
`timescale 1ns/1ns
`default_nettype none
`include "crg_cfg.svh"

module crg_hpf_decode (
    input wire logic [3:0] coeff_code,
    input wire logic bypass,
    output logic filter_on,
    output logic [3:0] shift_m1
);

    always_comb begin
        filter_on = (coeff_code != `CRG_HPF_OFF) && !bypass;
        // Shift of code plus one spans 2..16; carried as code to stay in four bits.
        shift_m1 = filter_on ? coeff_code : 4'h0;
    end

endmodule
`default_nettype wire

// ### sim/crg_chan0_regs_bench.sv
// Purpose: Self-checking bench for the channel 0 register slice.
// Assumes: Read data stand only in the cycle after the read strobe.
// Notes: The decoded configuration is checked two edges after each config write in the decode scenario.
`timescale 1ns/1ns
`default_nettype none
`include "crg_cfg.svh"

module crg_chan0_regs_bench;

    // ======================================================================
    // Clock, reset and ports
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic [`CRG_ADDR_W-1:0] reg_addr = '0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    crg_pkg::crg_chan_cfg_s chan_cfg;
    int failures = 0;
    int num_checks = 0;

    always #10 sys_clk = ~sys_clk;

    crg_chan0_regs dut (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .chan_cfg(chan_cfg)
    );

    // ======================================================================
    // Shared tasks
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [5:0] a, input logic [15:0] exp);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        check(24'(reg_rdata), 24'(exp));
    endtask

    // The decoded outputs trail the register by one edge.
    task automatic settle();
        repeat (2) @(posedge sys_clk);
        #1;
    endtask

    task automatic print_verdict();
        if (failures == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ======================================================================
    // Scenarios
    task automatic reset_values();
        for (int a = 7; a <= 11; a++) begin
            rd(6'(a), 16'h0000);
        end
        check(24'(chan_cfg != '0), 24'h000000);
        check(chan_cfg.detect_threshold, 24'h000000);
        check(chan_cfg.chan0_offset, 24'h000000);
    endtask

    // Writing all ones exposes every reserved bit that wrongly keeps data.
    task automatic masks();
        logic [15:0] exp [5];
        exp = '{16'hffff, 16'hff0f, 16'hffc7, 16'hffff, 16'hff00};
        for (int i = 0; i < 5; i++) begin
            wr(6'(7 + i), 16'hffff);
            rd(6'(7 + i), exp[i]);
            wr(6'(7 + i), 16'h0000);
            rd(6'(7 + i), 16'h0000);
        end
    endtask

    task automatic decode();
        wr(`CRG_ADDR_THR_HIGH, 16'h1234);
        wr(`CRG_ADDR_CH0_OFS_HIGH, 16'h8765);
        wr(`CRG_ADDR_CH0_OFS_LOW, 16'h4300);
        for (int c = 0; c < 16; c++) begin
            for (int b = 0; b < 2; b++) begin
                wr(`CRG_ADDR_THR_LOW, {8'hab, 4'h0, 4'(c)});
                wr(`CRG_ADDR_CHAN0_CONFIG, {10'h2a5, 3'b000, 1'(b), 2'b00});
                settle();
                check(24'(chan_cfg.chan0_highpass_on), 24'(c != 0 && b == 0));
                check(24'(chan_cfg.chan0_highpass_shift), (b == 0) ? 24'(c) : 24'h0);
            end
        end
        check(chan_cfg.detect_threshold, 24'h1234ab);
        check(chan_cfg.chan0_offset, 24'h876543);
        check(24'(chan_cfg.chan0_phase_delay), 24'h0002a5);
        for (int s = 0; s < 4; s++) begin
            wr(`CRG_ADDR_CHAN0_CONFIG, {10'h3ff, 4'h0, 2'(s)});
            settle();
            check(24'(chan_cfg.chan0_input_select), 24'(s));
            check(24'(chan_cfg.chan0_phase_delay), 24'h0003ff);
        end
    endtask

    // Write followed by a read with no idle cycle, then two stray addresses.
    task automatic back_to_back_unmapped();
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= `CRG_ADDR_CH0_OFS_HIGH;
        reg_wdata <= 16'h5a5a;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        check(24'(reg_rdata), 24'h005a5a);
        @(posedge sys_clk);
        #1;
        check(24'(reg_rdata), 24'h000000);
        wr(6'h0c, 16'hffff);
        wr(6'h3f, 16'hffff);
        rd(6'h0c, 16'h0000);
        rd(`CRG_ADDR_CH0_OFS_HIGH, 16'h5a5a);
        rd(`CRG_ADDR_CHAN0_CONFIG, 16'hffc3);
    endtask

    task automatic mid_reset();
        @(posedge sys_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        #1;
        check(24'(chan_cfg != '0), 24'h000000);
        check(chan_cfg.chan0_offset, 24'h000000);
        rd(`CRG_ADDR_CHAN0_CONFIG, 16'h0000);
        rd(`CRG_ADDR_CH0_OFS_HIGH, 16'h0000);
        rd(`CRG_ADDR_THR_LOW, 16'h0000);
    endtask

    // ======================================================================
    // Main sequence
    initial begin
        repeat (16) @(posedge sys_clk);
        rstn <= 1'b1;
        reset_values();
        masks();
        decode();
        back_to_back_unmapped();
        mid_reset();
        print_verdict();
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        print_verdict();
    end

endmodule

`default_nettype wire
